/* File: design/ivp_top.sv */
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ivp_top
  import ivp_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Straps and core side.
  input wire logic boot_reset_fuse,
  input wire logic [15:0] boot_start_addr,
  input wire logic [41:0] irq_req,
  input wire logic fetch_ack,
  output logic [15:0] reset_addr,
  output logic irq_valid,
  output logic [15:0] irq_addr,
  output logic irq_blocked,
  output logic debug_port_disable,
  output logic global_pullup_disable
);

  logic [7:0] ctrl_q;
  logic [2:0] unlock_cnt_q;
  logic block_q;
  logic ack_q;
  logic [5:0] slot_d;
  logic hit_d;
  logic ctrl_wr;
  logic stat_rd;

  // Reserved slots never dispatch, so they are masked before the search.
  logic [41:0] live_req;
  assign live_req = irq_req & ~IVP_RSVD_SLOTS;

  // Lowest slot wins, scanning downward so the last hit is the smallest.
  always_comb begin
    slot_d = 6'h00;
    hit_d = 1'b0;
    for (int i = IVP_NSLOT - 1; i >= 0; i--) begin
      if (live_req[i]) begin
        slot_d = 6'(i);
        hit_d = 1'b1;
      end
    end
  end

  // A write lands only at the edge where the master sees waitrequest low.
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == IVP_CTRL_OFS;
  assign stat_rd = avs_read && avs_address == IVP_STAT_OFS;

  // One wait state per access keeps the answer registered.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // Read data; unmapped offsets read zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      if (avs_address == IVP_CTRL_OFS) begin
        avs_readdata <= {24'h000000, ctrl_q};
      end else if (stat_rd) begin
        avs_readdata <= {8'h00, irq_addr, 6'h00, irq_blocked, irq_valid};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Control register; the select bit changes only inside an open unlock window.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= IVP_CTRL_RST;
      unlock_cnt_q <= 3'h0;
    end else if (ctrl_wr) begin
      ctrl_q[IVP_DEBUG_BIT] <= avs_writedata[IVP_DEBUG_BIT];
      ctrl_q[IVP_PULLUP_BIT] <= avs_writedata[IVP_PULLUP_BIT];
      if (ctrl_q[IVP_UNLOCK_BIT] && !avs_writedata[IVP_UNLOCK_BIT]) begin
        ctrl_q[IVP_SELECT_BIT] <= avs_writedata[IVP_SELECT_BIT];
        ctrl_q[IVP_UNLOCK_BIT] <= 1'b0;
        unlock_cnt_q <= 3'h0;
      end else if (avs_writedata[IVP_UNLOCK_BIT]) begin
        ctrl_q[IVP_UNLOCK_BIT] <= 1'b1;
        unlock_cnt_q <= IVP_UNLOCK_CNT;
      end
    end else if (unlock_cnt_q != 3'h0) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
      if (unlock_cnt_q == 3'h1) begin
        ctrl_q[IVP_UNLOCK_BIT] <= 1'b0;
      end
    end
  end

  // Blocking holds one extra cycle after the select write for the next instruction.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else begin
      block_q <= ctrl_q[IVP_UNLOCK_BIT] || (ctrl_wr && avs_writedata[IVP_UNLOCK_BIT]);
    end
  end

  // Reset address follows the fuse, sampled every cycle after release.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reset_addr <= IVP_RESET_ADDR;
    end else begin
      reset_addr <= boot_reset_fuse ? IVP_RESET_ADDR : boot_start_addr;
    end
  end

  // Vector output; the table is slot times two above the base.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_valid <= 1'b0;
      irq_addr <= IVP_VEC_BASE;
      irq_blocked <= 1'b0;
    end else begin
      irq_blocked <= block_q || ctrl_q[IVP_UNLOCK_BIT];
      irq_valid <= hit_d && !block_q && !ctrl_q[IVP_UNLOCK_BIT] && !fetch_ack
        && !(ctrl_wr && avs_writedata[IVP_UNLOCK_BIT]);
      irq_addr <= IVP_VEC_BASE + {9'h000, slot_d, 1'b0}
        + (ctrl_q[IVP_SELECT_BIT] ? boot_start_addr : 16'h0000);
    end
  end

  assign debug_port_disable = ctrl_q[IVP_DEBUG_BIT];
  assign global_pullup_disable = ctrl_q[IVP_PULLUP_BIT];

  // Unlock never outlives its four-cycle window.
  unlock_window_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(ctrl_q[IVP_UNLOCK_BIT]) |-> ##[1:5] !ctrl_q[IVP_UNLOCK_BIT])
    else $error("unlock bit held too long");

  // No dispatch while blocked.
  block_dispatch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_q[IVP_UNLOCK_BIT] |=> !irq_valid)
    else $error("vector presented during unlock");

  // Fuse unprogrammed gives address zero.
  reset_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    boot_reset_fuse |=> reset_addr == IVP_RESET_ADDR)
    else $error("reset address not zero");

  // Programmed fuse gives boot address.
  reset_boot_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !boot_reset_fuse |=> reset_addr == $past(boot_start_addr))
    else $error("reset address not boot");

  // Request 0 alone with select clear maps to the first slot.
  ext_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h1 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0002)
    else $error("request 0 vector wrong");

  // Fault event alone maps to the top slot.
  fault_slot_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h200_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0054)
    else $error("fault vector wrong");

  // Reserved-only requests never dispatch.
  rsvd_never_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (irq_req & ~IVP_RSVD_SLOTS) == 42'h0 |=> !irq_valid)
    else $error("reserved slot dispatched");

  // Select set offsets by the boot start.
  select_base_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h1 && ctrl_q[IVP_SELECT_BIT] |=> irq_addr == $past(boot_start_addr) + 16'h0002)
    else $error("relocated vector wrong");

  // Request 1 alone maps to the second slot.
  ext_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h2 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0004)
    else $error("request 1 vector wrong");

  // Request 3 alone maps to the fourth slot.
  ext_three_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h8 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0008)
    else $error("request 3 vector wrong");

  // Request 6 skips the two reserved slots below it.
  ext_six_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h40 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h000e)
    else $error("request 6 vector wrong");

  // Pin-change group 0 alone.
  pin_change_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h100 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0012)
    else $error("pin change vector wrong");

  // USB general event alone.
  usb_general_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h200 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0014)
    else $error("usb general vector wrong");

  // USB endpoint event alone.
  usb_endpoint_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h400 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0016)
    else $error("usb endpoint vector wrong");

  // Watchdog time-out alone.
  watchdog_slot_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h800 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0018)
    else $error("watchdog vector wrong");

  // First 16-bit timer capture alone.
  timer1_capture_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h8000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0020)
    else $error("timer 1 capture vector wrong");

  // First 16-bit timer compare C alone.
  timer1_compc_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h4_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0026)
    else $error("timer 1 compare c vector wrong");

  // First 16-bit timer overflow alone.
  timer1_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h8_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0028)
    else $error("timer 1 overflow vector wrong");

  // The 8-bit timer compare A alone.
  timer0_compa_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h10_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h002a)
    else $error("timer 0 compare a vector wrong");

  // The 8-bit timer overflow alone.
  timer0_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h40_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h002e)
    else $error("timer 0 overflow vector wrong");

  // SPI transfer complete alone.
  spi_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h80_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0030)
    else $error("spi vector wrong");

  // Serial receive complete alone.
  serial_rx_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h100_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0032)
    else $error("serial receive vector wrong");

  // Analog comparator alone.
  comparator_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h800_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0038)
    else $error("comparator vector wrong");

  // ADC conversion complete alone.
  adc_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h1000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h003a)
    else $error("adc vector wrong");

  // EEPROM ready alone.
  eeprom_ready_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h2000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h003c)
    else $error("eeprom ready vector wrong");

  // Two-wire serial interface alone.
  two_wire_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h8_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0048)
    else $error("two wire vector wrong");

  // Program store ready alone.
  store_ready_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h10_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h004a)
    else $error("store ready vector wrong");

  // Second 16-bit timer capture alone.
  timer3_capture_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h4000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h003e)
    else $error("timer 3 capture vector wrong");

  // Second 16-bit timer overflow alone.
  timer3_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h4_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0046)
    else $error("timer 3 overflow vector wrong");

  // High-speed timer compare A alone.
  hs_timer_compa_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h20_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h004c)
    else $error("high speed compare a vector wrong");

  // High-speed timer overflow alone.
  hs_timer_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req == 42'h100_0000_0000 && !ctrl_q[IVP_SELECT_BIT] |=> irq_addr == 16'h0052)
    else $error("high speed overflow vector wrong");

  // Request 0 always wins, whatever else is pending.
  lowest_first_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_req[0] |=> irq_addr == 16'h0002
      + ($past(ctrl_q[IVP_SELECT_BIT]) ? $past(boot_start_addr) : 16'h0000))
    else $error("lowest request not first");

  // A fetch acknowledge drops the vector for one cycle so it is not taken twice.
  fetch_gap_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fetch_ack |=> !irq_valid)
    else $error("vector held through acknowledge");

  // The blocking flag follows an open unlock window.
  blocked_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_q[IVP_UNLOCK_BIT] |=> irq_blocked)
    else $error("blocked flag missing");

  // A select write inside the window closes the window at once.
  select_clears_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_wr && ctrl_q[IVP_UNLOCK_BIT] && !avs_writedata[IVP_UNLOCK_BIT]
      |=> !ctrl_q[IVP_UNLOCK_BIT])
    else $error("unlock not cleared by select write");

  // Without an open window the select bit keeps its value.
  select_locked_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_wr && !ctrl_q[IVP_UNLOCK_BIT] |=> ctrl_q[IVP_SELECT_BIT] == $past(ctrl_q[IVP_SELECT_BIT]))
    else $error("select changed while locked");

  // Every new access gets exactly one wait state.
  wait_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (avs_read || avs_write) && !ack_q |=> !avs_waitrequest)
    else $error("access not answered");

  // An idle bus keeps waitrequest high.
  wait_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low while idle");

endmodule : ivp_top

/* File: design/ivp_pkg.sv */
package ivp_pkg;
  // Register byte offset of the general control register on the bus.
  localparam logic [3:0] IVP_CTRL_OFS = 4'h0;
  // Status register byte offset, shows the pending dispatch.
  localparam logic [3:0] IVP_STAT_OFS = 4'h4;
  // Field positions in the general control register.
  localparam int IVP_UNLOCK_BIT = 0;
  localparam int IVP_SELECT_BIT = 1;
  localparam int IVP_PULLUP_BIT = 4;
  localparam int IVP_DEBUG_BIT = 7;
  localparam logic [7:0] IVP_CTRL_RST = 8'h00;
  localparam logic [7:0] IVP_CTRL_WMASK = 8'h93;
  // Unlock window length in cycles.
  localparam int IVP_UNLOCK_CYC = 4;
  localparam logic [2:0] IVP_UNLOCK_CNT = 3'h4;
  // Program addresses (word addresses).
  localparam logic [15:0] IVP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] IVP_VEC_BASE = 16'h0002;
  localparam logic [15:0] IVP_BOOT_ADDR_RST = 16'h3800;
  // Number of interrupt slots, vectors 2..43.
  localparam int IVP_NSLOT = 42;
  // Slots that are reserved: vectors 6, 7, 9, 14, 15, 16 (slot = vector - 2).
  localparam logic [41:0] IVP_RSVD_SLOTS = 42'h000_0000_70b0;
endpackage : ivp_pkg

/* File: bench/ivp_core_model.sv */
`timescale 1ns/1ps
// Fetch side of the core: takes a presented vector after a settable lag.
module ivp_core_model #(
  parameter int LAG = 2
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Vector side.
  input wire logic go,
  input wire logic irq_valid,
  input wire logic [15:0] irq_addr,
  output logic fetch_ack,
  output logic [15:0] took_q
);
  int cnt_q;
  // A slow core leaves the vector pending for LAG + 1 cycles, which stresses the hold of irq_addr.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
      fetch_ack <= 1'b0;
      took_q <= 16'h0000;
    end else begin
      fetch_ack <= 1'b0;
      if (go && irq_valid && !fetch_ack) begin
        cnt_q <= (cnt_q == LAG) ? 0 : cnt_q + 1;
        if (cnt_q == LAG) begin
          fetch_ack <= 1'b1;
          took_q <= irq_addr;
        end
      end else begin
        cnt_q <= 0;
      end
    end
  end
endmodule : ivp_core_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import ivp_pkg::*;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, boot_reset_fuse, go;
  logic fetch_ack, irq_valid, irq_blocked, dbg, pullup_dis, rsv;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] boot_start_addr, reset_addr, irq_addr, took;
  logic [41:0] irq_req;
  int errors, checks;
  ivp_top i_ivp_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(boot_start_addr), .irq_req(irq_req),
    .fetch_ack(fetch_ack), .reset_addr(reset_addr), .irq_valid(irq_valid), .irq_addr(irq_addr),
    .irq_blocked(irq_blocked), .debug_port_disable(dbg), .global_pullup_disable(pullup_dis));
  ivp_core_model #(.LAG(3)) i_ivp_core_model (.mclk(mclk), .reset_n(reset_n), .go(go),
    .irq_valid(irq_valid), .irq_addr(irq_addr), .fetch_ack(fetch_ack), .took_q(took));
  // Free-running system clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bus access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : do_reset
  // Outputs are registered, so give the request three edges to show.
  task automatic put_irq(input logic [41:0] r);
    @(posedge mclk);
    irq_req <= r;
    repeat (3) @(posedge mclk);
  endtask : put_irq
  task automatic t_regs;
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(reset_addr, 16'h0000);
    bus(1'b1, IVP_CTRL_OFS, 32'h92);
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h90);
    chk({dbg, pullup_dis}, 2'b11);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    boot_reset_fuse <= 1'b0;
    do_reset();
    chk(reset_addr, boot_start_addr);
    boot_reset_fuse <= 1'b1;
    do_reset();
    $display("test regs done");
  endtask : t_regs
  task automatic t_table;
    for (int v = 2; v <= 43; v++) begin
      put_irq(42'h1 << (v - 2));
      rsv = v inside {6, 7, 9, 14, 15, 16};
      chk(irq_valid, !rsv);
      if (!rsv) chk(irq_addr, 16'(2 * v - 2));
    end
    put_irq((42'h1 << 5) | (42'h1 << 11) | (42'h1 << 38));
    chk(irq_addr, 16'h0018);
    $display("test table done");
  endtask : t_table
  task automatic t_move;
    put_irq(42'h1);
    bus(1'b1, IVP_CTRL_OFS, 32'h01);
    bus(1'b1, IVP_CTRL_OFS, 32'h02);
    chk({irq_blocked, irq_valid}, 2'b10);
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h02);
    repeat (8) @(posedge mclk);
    chk({irq_blocked, irq_valid}, 2'b01);
    chk(irq_addr, boot_start_addr + IVP_VEC_BASE);
    bus(1'b0, IVP_STAT_OFS, 32'h0);
    chk(rd, {8'h00, boot_start_addr + IVP_VEC_BASE, 8'h01});
    chk(reset_addr, 16'h0000);
    go <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(took, boot_start_addr + IVP_VEC_BASE);
    go <= 1'b0;
    bus(1'b1, IVP_CTRL_OFS, 32'h01);
    bus(1'b1, IVP_CTRL_OFS, 32'h00);
    bus(1'b1, IVP_CTRL_OFS, 32'h02);
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h00);
    bus(1'b1, IVP_CTRL_OFS, 32'h01);
    repeat (8) @(posedge mclk);
    chk(irq_blocked, 1'b0);
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h00);
    bus(1'b1, IVP_CTRL_OFS, 32'h02);
    bus(1'b0, IVP_CTRL_OFS, 32'h0);
    chk(rd, 32'h00);
    $display("test move done");
  endtask : t_move
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // The whole run needs a few hundred cycles; this cuts off a hung handshake.
  initial begin
    #80000;
    errors++;
    report_and_stop();
  end
  initial begin
    {reset_n, avs_read, avs_write, go} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    boot_reset_fuse = 1'b1;
    boot_start_addr = 16'h1c00;
    irq_req = 42'h0;
    errors = 0;
    checks = 0;
    do_reset();
    t_regs();
    t_table();
    t_move();
    report_and_stop();
  end
endmodule : tb
